// *** hw/mms_defs.svh ***
// Purpose: constants of the modulator mode selector
// Assumes: 200 MHz internal clock
// Notes:   times are printed figures; cycle counts derive from them
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH

`define MMS_CLK_MHZ       200
`define MMS_PULSES_NEEDED 4'h8
`define MMS_SPACING_MS    25
`define MMS_WINDOW_MS     250
`define MMS_ALERT_US      100
`define MMS_SPACING_CYC   (`MMS_SPACING_MS * 1000 * `MMS_CLK_MHZ)
`define MMS_WINDOW_CYC    (`MMS_WINDOW_MS * 1000 * `MMS_CLK_MHZ)
`define MMS_ALERT_CYC     (`MMS_ALERT_US * `MMS_CLK_MHZ)

`endif

// *** hw/mms_pkg.sv ***
// Purpose: types of the modulator mode selector
// Assumes: nothing
// Notes:   gray codes along init -> standalone -> bypass
package mms_pkg;

    typedef enum logic [1:0] {
        MMS_INIT         = 2'b00,
        MMS_STANDALONE   = 2'b01,
        MMS_BYPASS_SA    = 2'b11,
        MMS_BYPASS_FIXED = 2'b10
    } mms_mode_t;

endpackage

// *** hw/mms_pulse_window.sv ***
// Purpose: pulse spacing and activity window measurement
// Assumes: edge_seen is a one-cycle pulse per rising edge
// Notes:   takeover and stall are one-cycle pulses
`timescale 1ns/1ps
`include "mms_defs.svh"

module mms_pulse_window #(
    parameter int unsigned SPACING_CYC = `MMS_SPACING_CYC,
    parameter int unsigned WINDOW_CYC  = `MMS_WINDOW_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic edge_seen,
    input  wire logic window_run,
    output logic      takeover,
    output logic      stall
);
    import mms_pkg::*;

    logic [31:0] gap_r;
    logic [3:0]  run_r;
    logic [31:0] win_r;
    logic [3:0]  win_cnt_r;
    logic        gap_open;
    logic        win_end;

    // ********************************************************
    // pulse spacing
    // ********************************************************
    // a gap that reaches the limit breaks the run of pulses
    // gap_r trails the true gap by one cycle, so a gap of exactly the limit is refused
    assign gap_open = (gap_r < SPACING_CYC - 32'h1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_r <= 32'h0;
        end else if (edge_seen) begin
            gap_r <= 32'h0;
        end else if (gap_open) begin
            gap_r <= gap_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 4'h0;
        end else if (edge_seen) begin
            if (run_r == 4'h0 || !gap_open) begin
                run_r <= 4'h1;
            end else if (run_r != `MMS_PULSES_NEEDED) begin
                run_r <= run_r + 4'h1;
            end
        end else if (!gap_open) begin
            run_r <= 4'h0;
        end
    end

    assign takeover = edge_seen && gap_open && (run_r == `MMS_PULSES_NEEDED - 4'h1);

    // ********************************************************
    // activity window
    // ********************************************************
    assign win_end = window_run && (win_r == WINDOW_CYC - 32'h1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            win_r     <= 32'h0;
            win_cnt_r <= 4'h0;
        end else if (!window_run || win_end) begin
            win_r     <= 32'h0;
            win_cnt_r <= 4'h0;
        end else begin
            win_r <= win_r + 32'h1;
            if (edge_seen && win_cnt_r != `MMS_PULSES_NEEDED) begin
                win_cnt_r <= win_cnt_r + 4'h1;
            end
        end
    end

    // the edge of the final cycle still counts toward the window
    assign stall = win_end && ((win_cnt_r + {3'h0, edge_seen}) < `MMS_PULSES_NEEDED);

    AST_RUN_BREAK: assert property (@(posedge clk) disable iff (!rstn)
        (!gap_open && !edge_seen) |=> (run_r == 4'h0))
        else $error("pulse run kept across an over-long gap");

    AST_TAKE_NEEDS_RUN: assert property (@(posedge clk) disable iff (!rstn)
        takeover |-> (run_r == 4'h7) && edge_seen)
        else $error("takeover without seven prior closely spaced pulses");

endmodule

// *** hw/mms_top.sv ***
// Purpose: choose the source that drives the load modulation switches
// Assumes: strap comparator and demodulator outputs are synchronous to clk
// Notes:   host_interrupt_n_i is kept for the pin model only
`timescale 1ns/1ps
`include "mms_defs.svh"

module mms_top #(
    parameter int unsigned SPACING_CYC   = `MMS_SPACING_CYC,
    parameter int unsigned WINDOW_CYC    = `MMS_WINDOW_CYC,
    parameter int unsigned ALERT_CYC     = `MMS_ALERT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        modulation_config_strap,
    input  wire logic        mcu_modulation_input,
    input  wire logic        modulator_bit,
    input  wire logic        attention_cmd,
    output logic             load_switch_one,
    output logic             load_switch_two,
    input  wire logic        host_interrupt_n_i,
    output logic             host_interrupt_n_o,
    output logic             host_interrupt_n_oe,
    output mms_pkg::mms_mode_t mode
);
    import mms_pkg::*;

    mms_mode_t   mode_r;
    logic        meta_r;
    logic        sync_r;
    logic        sync_d_r;
    logic        edge_seen;
    logic        takeover;
    logic        stall;
    logic        switch_nxt;
    logic        switch_r;
    logic        switch_two_r;
    logic [31:0] alert_cnt_r;
    logic        alert_oe_r;
    logic        alert_seen_r;

    // ********************************************************
    // input synchroniser
    // ********************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r   <= 1'b0;
            sync_r   <= 1'b0;
            sync_d_r <= 1'b0;
        end else begin
            meta_r   <= mcu_modulation_input;
            sync_r   <= meta_r;
            sync_d_r <= sync_r;
        end
    end

    assign edge_seen = sync_r && !sync_d_r;

    // ********************************************************
    // activity measurement
    // ********************************************************
    mms_pulse_window #(
        .SPACING_CYC (SPACING_CYC),
        .WINDOW_CYC  (WINDOW_CYC)
    ) u_window (
        .clk         (clk),
        .rstn        (rstn),
        .edge_seen   (edge_seen),
        .window_run  (mode_r == MMS_BYPASS_SA),
        .takeover    (takeover),
        .stall       (stall)
    );

    // ********************************************************
    // mode control
    // ********************************************************
    // strap is caught on the first edge after release, never under reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= MMS_INIT;
        end else begin
            unique case (mode_r)
                MMS_INIT: begin
                    if (modulation_config_strap) begin
                        mode_r <= MMS_STANDALONE;
                    end else begin
                        mode_r <= MMS_BYPASS_FIXED;
                    end
                end
                MMS_STANDALONE: begin
                    if (takeover) begin
                        mode_r <= MMS_BYPASS_SA;
                    end
                end
                MMS_BYPASS_SA: begin
                    // the mcu holds control only by staying active
                    if (stall) begin
                        mode_r <= MMS_STANDALONE;
                    end
                end
                MMS_BYPASS_FIXED: begin
                    mode_r <= MMS_BYPASS_FIXED;
                end
            endcase
        end
    end

    // ********************************************************
    // load switch drive
    // ********************************************************
    always_comb begin
        unique case (mode_r)
            MMS_STANDALONE:   switch_nxt = modulator_bit;
            MMS_BYPASS_SA:    switch_nxt = sync_r;
            MMS_BYPASS_FIXED: switch_nxt = sync_r;
            MMS_INIT:         switch_nxt = 1'b0;
        endcase
    end

    // one flop per switch keeps each output straight from a register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            switch_r     <= 1'b0;
            switch_two_r <= 1'b0;
        end else begin
            switch_r     <= switch_nxt;
            switch_two_r <= switch_nxt;
        end
    end

    // ********************************************************
    // host interrupt
    // ********************************************************
    // a repeated command restarts the low time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_cnt_r <= 32'h0;
            alert_oe_r  <= 1'b0;
        end else if (attention_cmd) begin
            alert_cnt_r <= ALERT_CYC - 32'h1;
            alert_oe_r  <= 1'b1;
        end else if (alert_cnt_r != 32'h0) begin
            alert_cnt_r <= alert_cnt_r - 32'h1;
        end else begin
            alert_oe_r  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_seen_r <= 1'b0;
        end else if (attention_cmd) begin
            alert_seen_r <= 1'b1;
        end
    end

    assign load_switch_one     = switch_r;
    assign load_switch_two     = switch_two_r;
    assign host_interrupt_n_o  = 1'b0;
    assign host_interrupt_n_oe = alert_oe_r;
    assign mode                = mode_r;

    // ********************************************************
    // checks
    // ********************************************************
    sequence seq_strap_high;
        (mode_r == MMS_INIT) && modulation_config_strap;
    endsequence

    sequence seq_alert_req;
        attention_cmd ##1 host_interrupt_n_oe;
    endsequence

    AST_STRAP_STANDALONE: assert property (@(posedge clk) disable iff (!rstn)
        seq_strap_high |=> (mode_r == MMS_STANDALONE))
        else $error("high strap did not start standalone");

    AST_FIXED_STAYS: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r == MMS_BYPASS_FIXED) |=> (mode_r == MMS_BYPASS_FIXED))
        else $error("fixed bypass left its mode");

    AST_TAKEOVER_ENTERS: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r == MMS_STANDALONE) && takeover |=> (mode_r == MMS_BYPASS_SA))
        else $error("takeover did not enter bypass");

    AST_STALL_RETURNS: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r == MMS_BYPASS_SA) && stall |=> (mode_r == MMS_STANDALONE))
        else $error("stalled bypass did not fall back");

    AST_BYPASS_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r == MMS_BYPASS_SA || mode_r == MMS_BYPASS_FIXED)
        |=> (load_switch_one == $past(sync_r)) && (load_switch_two == $past(sync_r)))
        else $error("switches do not follow the mcu input in bypass");

    AST_SWITCH_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
        $rose(load_switch_one) |-> $past(modulator_bit) || $past(sync_r))
        else $error("switch closed with no bit being sent");

    AST_ALERT_LOW: assert property (@(posedge clk) disable iff (!rstn)
        attention_cmd |=> host_interrupt_n_oe ##1 host_interrupt_n_oe)
        else $error("attention command did not pull the interrupt low");

    AST_ALERT_SEQ: assert property (@(posedge clk) disable iff (!rstn)
        seq_alert_req |-> (host_interrupt_n_o == 1'b0))
        else $error("interrupt pin driven high");

    AST_ALERT_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        !alert_seen_r |-> !host_interrupt_n_oe)
        else $error("interrupt asserted before any command");

endmodule

// *** tb/mms_mcu_model.sv ***
// Purpose: microcontroller model driving the modulation input
// Assumes: called from the bench just after a rising clock edge
// Notes:   the pin starts low and each pulse ends low, so it idles low between bursts
`timescale 1ns/1ps

module mms_mcu_model (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'b0;

    // high for half the spacing so both levels last at least two cycles
    task automatic burst(input int n, input int gap);
        repeat (n) begin
            pin <= 1'b1;
            repeat (gap / 2) @(posedge clk);
            pin <= 1'b0;
            repeat (gap - gap / 2) @(posedge clk);
        end
    endtask
endmodule

// *** tb/mms_top_bench.sv ***
// Purpose: self-checking bench of the modulator mode selector
// Assumes: shortened spacing, window and interrupt counts
// Notes:   switch source checks wait until the mode has settled for a few cycles; sw2 is checked against sw1 every cycle out of reset
`timescale 1ns/1ps

module mms_top_bench;
    import mms_pkg::*;
    localparam int SP = 50;
    localparam int WN = 500;
    localparam int AL = 20;
    logic       clk     = 1'b0;
    logic       rstn    = 1'b0;
    logic       strap   = 1'b1;
    logic       mbit    = 1'b0;
    logic       att     = 1'b0;
    logic       alerted = 1'b0;
    logic       mb_h    = 1'b0;
    logic [2:0] pin_h   = 3'h0;
    logic       pin;
    logic       sw1;
    logic       sw2;
    logic       int_o;
    logic       int_oe;
    logic       int_pin;
    mms_mode_t  mode;
    mms_mode_t  last_mode;
    int         n_errors = 0;
    int         checked  = 0;
    int         stable   = 0;
    int         seed_v;

    always #2.5 clk = ~clk;

    // the open-drain pin rests high on its pull-up whenever it is released
    assign int_pin = (int_oe === 1'b1) ? int_o : 1'b1;

    mms_mcu_model i_mms_mcu_model (.clk(clk), .pin(pin));

    mms_top #(.SPACING_CYC(SP), .WINDOW_CYC(WN), .ALERT_CYC(AL)) i_mms_top (
        .clk(clk), .rstn(rstn), .modulation_config_strap(strap),
        .mcu_modulation_input(pin), .modulator_bit(mbit), .attention_cmd(att),
        .load_switch_one(sw1), .load_switch_two(sw2), .host_interrupt_n_i(int_pin),
        .host_interrupt_n_o(int_o), .host_interrupt_n_oe(int_oe), .mode(mode));

    task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // ****************************************
    // reference of the switch source
    // ****************************************
    always @(posedge clk) begin
        mbit  <= 1'($urandom_range(1, 0));
        mb_h  <= mbit;
        pin_h <= {pin_h[1:0], pin};
    end

    always @(negedge clk) begin
        stable    = (mode === last_mode) ? stable + 1 : 0;
        last_mode = mode;
        if (!rstn) cmp({sw1, int_oe}, 2'h0);
        if (rstn && !alerted) cmp(int_oe, 1'b0);
        if (rstn && !alerted) cmp(int_pin, 1'b1);
        if (rstn) cmp(sw2, sw1);
        if (rstn && stable > 2 && mode === MMS_STANDALONE) cmp(sw1, mb_h);
        if (rstn && stable > 2 && mode[1] === 1'b1) cmp(sw1, pin_h[2]);
    end

    task automatic do_reset(input logic s);
        rstn    <= 1'b0;
        strap   <= s;
        alerted <= 1'b0;
        repeat (12) @(posedge clk);
        rstn    <= 1'b1;
    endtask

    task automatic wait_mode(input mms_mode_t m, input int bound);
        int i;
        i = 0;
        while (mode !== m && i < bound) begin
            @(negedge clk);
            i++;
        end
        // look at the mode while it is settled, then hand back on a rising edge
        @(negedge clk);
        cmp(mode, m);
        @(posedge clk);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        int n;
        seed_v = $urandom(32'h9AB81C9D);
        do_reset(1'b1);
        wait_mode(MMS_STANDALONE, 3);
        repeat (60) @(posedge clk);
        i_mms_mcu_model.burst(7, 10);
        repeat (SP + 10) @(posedge clk);
        cmp(mode, MMS_STANDALONE);
        i_mms_mcu_model.burst(8, SP);
        cmp(mode, MMS_STANDALONE);
        $display("test spacing refusals done");
        i_mms_mcu_model.burst(8, int'($urandom_range(SP - 2, 4)));
        wait_mode(MMS_BYPASS_SA, 10);
        i_mms_mcu_model.burst(30, 20);
        cmp(mode, MMS_BYPASS_SA);
        i_mms_mcu_model.burst(7, 20);
        wait_mode(MMS_STANDALONE, 2 * WN + 50);
        $display("test takeover and fallback done");
        alerted <= 1'b1;
        att     <= 1'b1;
        @(posedge clk);
        att     <= 1'b0;
        n = 0;
        repeat (AL + 6) begin
            @(negedge clk);
            if (int_oe === 1'b1) n++;
            if (int_oe === 1'b1) cmp(int_o, 1'b0);
            if (int_oe === 1'b1) cmp(int_pin, 1'b0);
        end
        cmp(n == AL, 1'b1);
        $display("test attention done");
        @(posedge clk);
        do_reset(1'b0);
        wait_mode(MMS_BYPASS_FIXED, 3);
        i_mms_mcu_model.burst(8, 10);
        repeat (2 * WN + 20) @(posedge clk);
        cmp(mode, MMS_BYPASS_FIXED);
        $display("test grounded strap done");
        stop_test();
    end
endmodule
